// *** shared/pod_pkg.sv ***
// register map, reset values, keys and helpers for the override/duty block
// How it works
// - override select bit 1 routes the generator output to that pin
// - override select bit 0 drives the pin from its manual output bit
// - manual output bit 1 with select cleared forces the pin active
// - manual output bit 0 with select cleared forces the pin inactive
// - override bits 15-14 and 7-6 hold nothing and read as zero
// - three 16-bit read/write duty registers, zero after reset
// - 16-bit read/write unlock key register, zero after reset
// - with lock input high, protected writes need the key sequence first
`default_nettype none
package pod_pkg;
  // byte addresses on the register bus
  localparam logic [7:0]  OFF_OVR       = 8'h00;
  localparam logic [7:0]  OFF_DC1       = 8'h04;
  localparam logic [7:0]  OFF_DC2       = 8'h08;
  localparam logic [7:0]  OFF_DC3       = 8'h0C;
  localparam logic [7:0]  OFF_KEY       = 8'h10;
  localparam logic [7:0]  OFF_PROT      = 8'h14;
  localparam logic [7:0]  OFF_STAT      = 8'h18;
  // override register layout
  localparam int          PIN_N         = 6;
  localparam int          OVR_SEL_LSB   = 8;
  localparam int          OVR_MAN_LSB   = 0;
  localparam logic [15:0] OVR_RSV_MASK  = 16'hC0C0;
  // status register layout
  localparam int          STAT_UNLK_BIT = 0;
  localparam int          STAT_LOCK_BIT = 1;
  // reset values
  localparam logic [15:0] OVR_RST       = 16'h3F00;
  localparam logic [15:0] DUTY_RST      = 16'h0000;
  localparam logic [15:0] KEY_RST       = 16'h0000;
  localparam logic [15:0] PROT_RST      = 16'h0000;
  // unlock sequence values, first then second
  localparam logic [15:0] KEY_FIRST     = 16'hA5A5;
  localparam logic [15:0] KEY_SECOND    = 16'h5A5A;

  // unlock sequence states
  typedef enum logic [1:0] {UNL_IDLE, UNL_HALF, UNL_OPEN} pod_unl_state_t;

  // byte-lane merge of a bus write into a 16-bit register
  function automatic logic [15:0] pod_merge(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : pod_merge
endpackage : pod_pkg
`default_nettype wire

// *** rtl/pod_unlock.sv ***
// unlock sequence tracker guarding the protected configuration register
`timescale 1ns/1ns
`default_nettype none
module pod_unlock
  import pod_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // accepted writes
  input  wire logic        key_wr,
  input  wire logic [15:0] key_val,
  input  wire logic        prot_wr,
  // state
  output logic             unlocked
);
  pod_unl_state_t state_q;

  // two key writes in order open one protected write
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= UNL_IDLE;
    end else if (key_wr) begin
      state_q <= (key_val == KEY_FIRST) ? UNL_HALF : UNL_IDLE;
      if (state_q == UNL_HALF && key_val == KEY_SECOND) begin
        state_q <= UNL_OPEN;
      end
    end else if (prot_wr) begin
      state_q <= UNL_IDLE; // relock after one write
    end
  end

  assign unlocked = (state_q == UNL_OPEN);

  sequence key_first_s;
    key_wr && key_val == KEY_FIRST;
  endsequence
  sequence key_second_s;
    key_wr && key_val == KEY_SECOND;
  endsequence

  key_pair_opens_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    key_first_s ##1 (!key_wr && !prot_wr) ##1 key_second_s |=> unlocked)
    else $error("key pair did not unlock");

  write_relocks_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (unlocked && prot_wr && !key_wr) |=> !unlocked)
    else $error("protected write did not relock");

  lone_key_shut_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (state_q != UNL_HALF && key_wr && key_val != KEY_FIRST) |=> !unlocked ##1 !unlocked)
    else $error("wrong key opened the lock");
endmodule : pod_unlock
`default_nettype wire

// *** rtl/pod_top.sv ***
// override control, duty and unlock registers behind an Avalon-MM slave
`timescale 1ns/1ns
`default_nettype none
module pod_top
  import pod_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // generator core outputs
  input  wire logic [2:0]  gen_high,
  input  wire logic [2:0]  gen_low,
  // lock configuration input
  input  wire logic        write_protect_config,
  // power stage pins
  output logic      [2:0]  high_side_outputs,
  output logic      [2:0]  low_side_outputs,
  // values to the generator core
  output logic      [15:0] duty_one,
  output logic      [15:0] duty_two,
  output logic      [15:0] duty_three,
  output logic      [15:0] prot_config
);
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [15:0] ovr_q;
  logic [15:0] dc1_q;
  logic [15:0] dc2_q;
  logic [15:0] dc3_q;
  logic [15:0] key_q;
  logic [15:0] prot_q;
  logic [5:0]  pin_q;
  logic [5:0]  pin_d;
  logic [5:0]  gen_vec;
  logic [5:0]  sel;
  logic [5:0]  man;
  logic        wr_go;
  logic        rd_go;
  logic        key_wr;
  logic        prot_wr;
  logic        prot_ok;
  logic        unlocked;
  logic [31:0] rd_mux;

  // bus handshake: one wait cycle, then the access completes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_q <= 1'b0;
    end
  end

  assign wr_go   = avs_write && !wait_q;
  assign rd_go   = avs_read && !wait_q;
  assign key_wr  = wr_go && avs_address == OFF_KEY;
  assign prot_wr = wr_go && avs_address == OFF_PROT && prot_ok;
  // lock input low: always writable; high: only when opened
  assign prot_ok = !write_protect_config || unlocked;

  // override control, unused bits never stored
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ovr_q <= OVR_RST;
    end else if (wr_go && avs_address == OFF_OVR) begin
      ovr_q <= pod_merge(ovr_q, avs_writedata, avs_byteenable) & ~OVR_RSV_MASK;
    end
  end

  // duty cycle values
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dc1_q <= DUTY_RST;
      dc2_q <= DUTY_RST;
      dc3_q <= DUTY_RST;
    end else if (wr_go) begin
      if (avs_address == OFF_DC1) begin
        dc1_q <= pod_merge(dc1_q, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFF_DC2) begin
        dc2_q <= pod_merge(dc2_q, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFF_DC3) begin
        dc3_q <= pod_merge(dc3_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // unlock key, stored and fed to the sequence tracker
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      key_q <= KEY_RST;
    end else if (key_wr) begin
      key_q <= pod_merge(key_q, avs_writedata, avs_byteenable);
    end
  end

  // protected configuration, write dropped while locked
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prot_q <= PROT_RST;
    end else if (prot_wr) begin
      prot_q <= pod_merge(prot_q, avs_writedata, avs_byteenable);
    end
  end

  pod_unlock u_unlock (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .key_wr   (key_wr),
    .key_val  (pod_merge(key_q, avs_writedata, avs_byteenable)),
    .prot_wr  (prot_wr),
    .unlocked (unlocked)
  );

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      OFF_OVR:  rd_mux = {16'h0000, ovr_q & ~OVR_RSV_MASK};
      OFF_DC1:  rd_mux = {16'h0000, dc1_q};
      OFF_DC2:  rd_mux = {16'h0000, dc2_q};
      OFF_DC3:  rd_mux = {16'h0000, dc3_q};
      OFF_KEY:  rd_mux = {16'h0000, key_q};
      OFF_PROT: rd_mux = {16'h0000, prot_q};
      OFF_STAT: begin
        rd_mux[STAT_UNLK_BIT] = unlocked;
        rd_mux[STAT_LOCK_BIT] = write_protect_config;
      end
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured as the wait state ends
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // pin order in vectors: 1L,1H,2L,2H,3L,3H from bit 0 up
  assign gen_vec = {gen_high[2], gen_low[2], gen_high[1], gen_low[1],
                    gen_high[0], gen_low[0]};
  assign sel     = ovr_q[OVR_SEL_LSB +: PIN_N];
  assign man     = ovr_q[OVR_MAN_LSB +: PIN_N];

  // per pin: generator when selected, else manual level
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      if (sel[i]) begin
        pin_d[i] = gen_vec[i];
      end else begin
        pin_d[i] = man[i];
      end
    end
  end

  // pin flops, all inactive during reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_q <= 6'h00;
    end else begin
      pin_q <= pin_d;
    end
  end

  // outputs straight from flops
  assign high_side_outputs = {pin_q[5], pin_q[3], pin_q[1]};
  assign low_side_outputs  = {pin_q[4], pin_q[2], pin_q[0]};
  assign duty_one          = dc1_q;
  assign duty_two          = dc2_q;
  assign duty_three        = dc3_q;
  assign prot_config       = prot_q;
  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;

  gen_route_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> (pin_q & $past(sel)) == ($past(gen_vec) & $past(sel)))
    else $error("selected pin does not follow generator");

  manual_route_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> (pin_q & ~$past(sel)) == ($past(man) & ~$past(sel)))
    else $error("overridden pin does not follow manual bit");

  force_active_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (~sel & man) != 6'h00 |=> (($past(~sel & man) & ~pin_q) == 6'h00))
    else $error("manual one did not drive pin active");

  force_inactive_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (~sel & ~man) != 6'h00 |=> (($past(~sel & ~man) & pin_q) == 6'h00))
    else $error("manual zero did not drive pin inactive");

  unused_zero_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd_go && avs_address == OFF_OVR) |->
      (avs_readdata & {16'hFFFF, OVR_RSV_MASK}) == 32'h0000_0000)
    else $error("unused override bits read nonzero");

  duty_write_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_go && avs_address == OFF_DC2 && avs_byteenable == 4'hF) |=>
      duty_two == $past(avs_writedata[15:0]) && wait_q)
    else $error("duty value write lost");

  key_readback_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (key_wr && avs_byteenable == 4'hF) ##1 (avs_read && avs_address == OFF_KEY) ##1
      rd_go |-> avs_readdata[15:0] == $past(avs_writedata[15:0], 2))
    else $error("key register readback wrong");

  locked_hold_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_go && avs_address == OFF_PROT && write_protect_config && !unlocked) |=>
      $stable(prot_config))
    else $error("locked protected register changed");

  free_write_a : assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_go && avs_address == OFF_PROT && !write_protect_config &&
      avs_byteenable == 4'hF) |=> prot_config == $past(avs_writedata[15:0]))
    else $error("unlocked protected write lost");
endmodule : pod_top
`default_nettype wire

// *** verif/pod_gate_drv.sv ***
// gate driver stand-in that latches the power stage pin levels
`timescale 1ns/1ns
`default_nettype none
module pod_gate_drv (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // pins from the block
  input  wire logic [2:0] high_in,
  input  wire logic [2:0] low_in,
  // switch states seen by the stage, 3H down to 1L
  output logic      [5:0] stage_q
);
  // one cycle of driver delay, switches off in reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stage_q <= 6'h00;
    end else begin
      stage_q <= {high_in[2], low_in[2], high_in[1], low_in[1], high_in[0], low_in[0]};
    end
  end
endmodule : pod_gate_drv
`default_nettype wire

// *** verif/pod_top_tb.sv ***
// self-checking bench for the override, duty and unlock registers
`timescale 1ns/1ns
`default_nettype none
module pod_top_tb
  import pod_pkg::*;
();
  logic        sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, lock;
  logic        b2b;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [2:0]  gen_high, gen_low, hs, ls;
  logic [15:0] d1, d2, d3, prot;
  logic [5:0]  stage_q;
  logic [15:0] ov [3] = '{16'h002A, 16'h0015, 16'h0F30};
  logic [5:0]  ex [3] = '{6'h2A, 6'h15, 6'h36};
  int          fails, checks_done;

  pod_top u_pod_top (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gen_high(gen_high), .gen_low(gen_low),
    .write_protect_config(lock), .high_side_outputs(hs), .low_side_outputs(ls),
    .duty_one(d1), .duty_two(d2), .duty_three(d3), .prot_config(prot));
  pod_gate_drv u_pod_gate_drv (.sys_clk(sys_clk), .rst_b(rst_b), .high_in(hs),
    .low_in(ls), .stage_q(stage_q));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one access: hold until waitrequest low is sampled, then release unless b2b is set
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20) begin
      fails++;
      complete_run();
    end
    // back to back: leave the request up for the next call to take over
    if (!b2b) begin
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000, 4'hF);
    chk(q, exp);
  endtask : rd

  // stage has seen the pins once three edges have passed
  task automatic pins(input logic [5:0] exp);
    repeat (3) @(posedge sys_clk);
    chk({26'h0, stage_q}, {26'h0, exp});
  endtask : pins

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {avs_read, avs_write, lock} = 3'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    {gen_high, gen_low} = 6'h00;
    fails = 0;
    checks_done = 0;
    b2b = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(OFF_OVR, {16'h0, OVR_RST});
    rd(OFF_DC1, 32'h0);
    rd(OFF_DC2, 32'h0);
    rd(OFF_DC3, 32'h0);
    rd(OFF_KEY, 32'h0);
    $display("test reset values done");
    wr(OFF_OVR, 16'hFFFF);
    rd(OFF_OVR, 32'h3F3F);
    gen_high <= 3'b101;
    gen_low <= 3'b010;
    pins(6'h26);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_OVR, ov[i]);
      pins(ex[i]);
    end
    $display("test override done");
    wr(OFF_DC1, 16'h1234);
    wr(OFF_DC2, 16'hFFFF);
    wr(OFF_DC3, 16'h8001);
    bus(1'b1, OFF_DC1, 16'hABCD, 4'h1);
    rd(OFF_DC1, 32'h12CD);
    rd(OFF_DC2, 32'hFFFF);
    rd(OFF_DC3, 32'h8001);
    chk({d1, d2}, 32'h12CDFFFF);
    chk({16'h0, d3}, 32'h8001);
    // key write then readback back to back
    b2b = 1'b1;
    wr(OFF_KEY, 16'hBEEF);
    b2b = 1'b0;
    rd(OFF_KEY, 32'hBEEF);
    $display("test duty and key done");
    lock <= 1'b1;
    wr(OFF_PROT, 16'h1234);
    chk({16'h0, prot}, 32'h0);
    rd(OFF_STAT, 32'h2);
    // key pair back to back
    b2b = 1'b1;
    wr(OFF_KEY, KEY_FIRST);
    b2b = 1'b0;
    wr(OFF_KEY, KEY_SECOND);
    rd(OFF_STAT, 32'h3);
    wr(OFF_PROT, 16'h1234);
    chk({16'h0, prot}, 32'h1234);
    wr(OFF_PROT, 16'h5555);
    chk({16'h0, prot}, 32'h1234);
    wr(OFF_KEY, KEY_FIRST);
    wr(OFF_KEY, 16'h0001);
    wr(OFF_KEY, KEY_SECOND);
    wr(OFF_PROT, 16'h5555);
    chk({16'h0, prot}, 32'h1234);
    lock <= 1'b0;
    wr(OFF_PROT, 16'h5555);
    chk({16'h0, prot}, 32'h5555);
    $display("test unlock done");
    wr(8'h1C, 16'hFFFF);
    rd(8'h1C, 32'h0);
    rd(8'h02, 32'h0);
    rd(OFF_OVR, 32'h0F30);
    $display("test unmapped done");
    complete_run();
  end
endmodule : pod_top_tb
`default_nettype wire
